// ---- include/mcs_pkg.sv ----
// constants, register map and state layout of the monitor register bank
// assumes a 10 MHz core clock; times are printed in ns and converted here
package mcs_pkg;

  // register pointers and reset values
  localparam logic [7:0]  PTR_CONFIG    = 8'h00;
  localparam logic [7:0]  PTR_SHUNT     = 8'h01;
  localparam logic [15:0] CONFIG_RESET  = 16'h399F;
  localparam logic [15:0] SHUNT_RESET   = 16'h0000;

  // configuration field positions
  localparam int CFG_RST_BIT     = 15;
  localparam int CFG_SPARE_BIT   = 14;
  localparam int CFG_RANGE_BIT   = 13;
  localparam int CFG_GAIN_HI     = 12;
  localparam int CFG_GAIN_LO     = 11;
  localparam int CFG_BUSCONV_HI  = 10;
  localparam int CFG_BUSCONV_LO  = 7;
  localparam int CFG_SHCONV_HI   = 6;
  localparam int CFG_SHCONV_LO   = 3;
  localparam int CFG_MODE_HI     = 2;
  localparam int CFG_MODE_LO     = 0;

  // full scale at gain 1, in 10 uV counts; doubled per gain step
  localparam logic [16:0] FS_GAIN1 = 17'h00FA0;

  // conversion times
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_9BIT_NS     = 84000;
  localparam int T_10BIT_NS    = 148000;
  localparam int T_11BIT_NS    = 276000;
  localparam int T_12BIT_NS    = 532000;
  localparam int T_AVG2_NS     = 1060000;
  localparam int T_AVG4_NS     = 2130000;
  localparam int T_AVG8_NS     = 4260000;
  localparam int T_AVG16_NS    = 8510000;
  localparam int T_AVG32_NS    = 17020000;
  localparam int T_AVG64_NS    = 34050000;
  localparam int T_AVG128_NS   = 68100000;
  localparam int CYC_9BIT   = (T_9BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_10BIT  = (T_10BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_11BIT  = (T_11BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_12BIT  = (T_12BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG2   = (T_AVG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG4   = (T_AVG4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG8   = (T_AVG8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG16  = (T_AVG16_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG32  = (T_AVG32_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG64  = (T_AVG64_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_AVG128 = (T_AVG128_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W    = 20;

  // write byte sequence: pointer, upper byte, lower byte, then ignore
  localparam logic [1:0] WR_PTR  = 2'd0;
  localparam logic [1:0] WR_MSB  = 2'd1;
  localparam logic [1:0] WR_LSB  = 2'd2;
  localparam logic [1:0] WR_DONE = 2'd3;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b001,
    PH_SHUNT = 3'b010,
    PH_BUS   = 3'b100
  } mcs_phase_type;

  typedef struct packed {
    logic [15:0]          cfg;
    logic [15:0]          shunt;
    logic [7:0]           ptr;
    logic [1:0]           wr_cnt;
    logic [7:0]           msb_hold;
    logic                 rd_lsb;
    logic [7:0]           rd_byte;
    mcs_phase_type        phase;
    logic [TIMER_W-1:0]   timer;
    logic                 restart;
  } mcs_state_type;

  localparam mcs_state_type STATE_RESET = '{
    cfg:      CONFIG_RESET,
    shunt:    SHUNT_RESET,
    ptr:      PTR_CONFIG,
    wr_cnt:   WR_DONE,
    msb_hold: 8'h00,
    rd_lsb:   1'b0,
    rd_byte:  8'h00,
    phase:    PH_IDLE,
    timer:    20'h00000,
    restart:  1'b1
  };

endpackage

// ---- design/mcs_monitor_regs.sv ----
// configuration and shunt result registers of the current monitor
// assumes a two-wire slave engine in front that delivers decoded bytes,
// and an analog front end that presents a signed shunt sample in 10 uV counts
// a config write commits on its lower byte; the 4 us read-back gap is the host's
// the shunt result reads zero until the first conversion ends
`timescale 1ns/10ps
module mcs_monitor_regs
  import mcs_pkg::*;
#(
  parameter int CYC_12BIT_P  = mcs_pkg::CYC_12BIT,
  parameter int CYC_AVG2_P   = mcs_pkg::CYC_AVG2,
  parameter int CYC_AVG4_P   = mcs_pkg::CYC_AVG4,
  parameter int CYC_AVG8_P   = mcs_pkg::CYC_AVG8,
  parameter int CYC_AVG16_P  = mcs_pkg::CYC_AVG16,
  parameter int CYC_AVG32_P  = mcs_pkg::CYC_AVG32,
  parameter int CYC_AVG64_P  = mcs_pkg::CYC_AVG64,
  parameter int CYC_AVG128_P = mcs_pkg::CYC_AVG128
)
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  // byte stream from the two-wire slave engine
  input  wire logic               wr_start_in,
  input  wire logic               wr_byte_valid_in,
  input  wire logic [7:0]         wr_byte_in,
  input  wire logic               rd_start_in,
  input  wire logic               rd_byte_req_in,
  input  wire logic               gen_call_rst_in,
  output logic [7:0]              rd_byte_out,
  // analog front end
  input  wire logic signed [16:0] shunt_sample_in,
  output logic                    shunt_conv_out,
  output logic                    bus_conv_out,
  output logic                    bus_range_select_out,
  output logic [1:0]              shunt_gain_field_out,
  output logic [3:0]              bus_conversion_setting_out,
  output logic [3:0]              shunt_conversion_setting_out,
  output logic [2:0]              op_mode_out
);
  import mcs_pkg::*;

  mcs_state_type state_reg;
  mcs_state_type state_next;

  // conversion length for one 4-bit setting
  function automatic logic [TIMER_W-1:0] conv_cycles(input logic [3:0] code);
    int n;
    n = CYC_12BIT_P;
    if (!code[3])
    begin
      case (code[1:0])
        2'b00:   n = CYC_9BIT;
        2'b01:   n = CYC_10BIT;
        2'b10:   n = CYC_11BIT;
        default: n = CYC_12BIT_P;
      endcase
    end
    else
    begin
      case (code[2:0])
        3'b000:  n = CYC_12BIT_P;
        3'b001:  n = CYC_AVG2_P;
        3'b010:  n = CYC_AVG4_P;
        3'b011:  n = CYC_AVG8_P;
        3'b100:  n = CYC_AVG16_P;
        3'b101:  n = CYC_AVG32_P;
        3'b110:  n = CYC_AVG64_P;
        default: n = CYC_AVG128_P;
      endcase
    end
    return TIMER_W'(n);
  endfunction

  // clamp a sample for the selected gain and narrow it to 16 bits
  function automatic logic [15:0] clamp_shunt(input logic signed [16:0] s,
                                              input logic [1:0] gain);
    logic signed [16:0] fs;
    logic signed [16:0] r;
    fs = $signed(FS_GAIN1 << gain);
    r  = s;
    if (s > fs)
    begin
      r = fs;
    end
    else if (s < -fs)
    begin
      r = -fs;
    end
    return r[15:0];
  endfunction

  // conversion length of each phase for a configuration word
  function automatic logic [TIMER_W-1:0] bus_cycles(input logic [15:0] cfg);
    return conv_cycles(cfg[CFG_BUSCONV_HI:CFG_BUSCONV_LO]);
  endfunction

  function automatic logic [TIMER_W-1:0] shunt_cycles(input logic [15:0] cfg);
    return conv_cycles(cfg[CFG_SHCONV_HI:CFG_SHCONV_LO]);
  endfunction

  logic [2:0]  mode;
  logic [15:0] word_sel;
  logic [15:0] new_cfg;

  assign mode = state_reg.cfg[CFG_MODE_HI:CFG_MODE_LO];

  always_comb
  begin
    state_next = state_reg;
    new_cfg    = {state_reg.msb_hold, wr_byte_in};
    // pointers other than the two registers read as zero
    word_sel   = 16'h0000;
    if (state_reg.ptr == PTR_CONFIG)
    begin
      word_sel = state_reg.cfg;
    end
    else if (state_reg.ptr == PTR_SHUNT)
    begin
      word_sel = state_reg.shunt;
    end

    // conversion sequencer: shunt phase, then bus phase, as the mode bits ask
    // a config write parks it and restarts it, so no phase ever runs under
    // a setting other than the one it was started with
    if (state_reg.restart)
    begin
      state_next.restart = 1'b0;
      if (mode[0])
      begin
        state_next.phase = PH_SHUNT;
        state_next.timer = shunt_cycles(state_reg.cfg);
      end
      else if (mode[1])
      begin
        state_next.phase = PH_BUS;
        state_next.timer = bus_cycles(state_reg.cfg);
      end
      else
      begin
        state_next.phase = PH_IDLE;
      end
    end
    else if (state_reg.phase != PH_IDLE && state_reg.timer > 20'h00001)
    begin
      state_next.timer = state_reg.timer - 20'h00001;
    end
    else
    begin
      case (state_reg.phase)
        PH_SHUNT:
        begin
          state_next.shunt = clamp_shunt(shunt_sample_in,
                               state_reg.cfg[CFG_GAIN_HI:CFG_GAIN_LO]);
          if (mode[1])
          begin
            state_next.phase = PH_BUS;
            state_next.timer = bus_cycles(state_reg.cfg);
          end
          else if (mode[2])
          begin
            // shunt-only continuous reloads with no idle cycle between rounds
            state_next.timer = shunt_cycles(state_reg.cfg);
          end
          else
          begin
            state_next.phase = PH_IDLE;
          end
        end
        PH_BUS:
        begin
          if (mode[2])
          begin
            state_next.restart = 1'b1;
            state_next.phase   = PH_IDLE;
          end
          else
          begin
            state_next.phase = PH_IDLE;
          end
        end
        PH_IDLE:
        begin
          state_next.phase = PH_IDLE;
        end
        default:
        begin
          state_next.phase = PH_IDLE;
        end
      endcase
    end

    // read side: upper byte first, then lower, alternating
    if (rd_start_in)
    begin
      state_next.rd_lsb = 1'b0;
    end
    else if (rd_byte_req_in)
    begin
      state_next.rd_byte = state_reg.rd_lsb ? word_sel[7:0] : word_sel[15:8];
      state_next.rd_lsb  = ~state_reg.rd_lsb;
    end

    // write side: pointer, upper byte, lower byte
    if (wr_start_in)
    begin
      state_next.wr_cnt = WR_PTR;
    end
    else if (wr_byte_valid_in)
    begin
      case (state_reg.wr_cnt)
        WR_PTR:
        begin
          state_next.ptr    = wr_byte_in;
          state_next.wr_cnt = WR_MSB;
          state_next.rd_lsb = 1'b0;
        end
        WR_MSB:
        begin
          state_next.msb_hold = wr_byte_in;
          state_next.wr_cnt   = WR_LSB;
        end
        WR_LSB:
        begin
          state_next.wr_cnt = WR_DONE;
          // the shunt result is read-only, other pointers hold nothing
          if (state_reg.ptr == PTR_CONFIG)
          begin
            if (new_cfg[CFG_RST_BIT])
            begin
              state_next = STATE_RESET;
            end
            else
            begin
              // spare bit 14 stores as written
              state_next.cfg     = new_cfg;
              state_next.restart = 1'b1;
              // drop a phase begun under the old setting
              state_next.phase   = PH_IDLE;
            end
          end
        end
        default:
        begin
          state_next.wr_cnt = WR_DONE;
        end
      endcase
    end

    if (gen_call_rst_in)
    begin
      state_next = STATE_RESET;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rd_byte_out                  = state_reg.rd_byte;
  assign shunt_conv_out               = (state_reg.phase == PH_SHUNT);
  assign bus_conv_out                 = (state_reg.phase == PH_BUS);
  assign bus_range_select_out         = state_reg.cfg[CFG_RANGE_BIT];
  assign shunt_gain_field_out         = state_reg.cfg[CFG_GAIN_HI:CFG_GAIN_LO];
  assign bus_conversion_setting_out   = state_reg.cfg[CFG_BUSCONV_HI:CFG_BUSCONV_LO];
  assign shunt_conversion_setting_out = state_reg.cfg[CFG_SHCONV_HI:CFG_SHCONV_LO];
  assign op_mode_out                  = mode;

endmodule

// ---- verif/mcs_monitor_regs_properties.sv ----
// assertion checker for the monitor register bank
// sees only ports of mcs_monitor_regs; the bind follows the module
`timescale 1ns/10ps
module mcs_regs_chk (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  // requests
  input wire logic       wr_byte_valid_in,
  input wire logic       gen_call_rst_in,
  // watched outputs
  input wire logic       shunt_conv_out,
  input wire logic       bus_conv_out,
  input wire logic       bus_range_select_out,
  input wire logic [1:0] shunt_gain_field_out,
  input wire logic [3:0] bus_conversion_setting_out,
  input wire logic [3:0] shunt_conversion_setting_out,
  input wire logic [2:0] op_mode_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  logic [13:0] fields;
  assign fields = {bus_range_select_out, shunt_gain_field_out, bus_conversion_setting_out,
                   shunt_conversion_setting_out, op_mode_out};
  sequence s_defaults;
    fields == 14'h399F;
  endsequence
  sequence s_quiet;
    !shunt_conv_out && !bus_conv_out;
  endsequence
  a_reset_defaults: assert property ($fell(sys_rst_in) |-> s_defaults)
    else $error("fields not at default after reset");
  a_gen_call_defaults: assert property (gen_call_rst_in |-> ##[1:2] s_defaults)
    else $error("general call did not restore defaults");
  a_fields_hold: assert property ($changed(fields) |-> $past(wr_byte_valid_in)
    || $past(wr_byte_valid_in, 2) || $past(gen_call_rst_in) || $past(gen_call_rst_in, 2))
    else $error("fields changed without a write");
  a_one_phase: assert property (!(shunt_conv_out && bus_conv_out))
    else $error("shunt and bus converting together");
  a_idle_modes: assert property (op_mode_out[1:0] == 2'b00 [*2] |-> s_quiet)
    else $error("converter active in off mode");
  a_shunt_mode: assert property ($rose(shunt_conv_out) |-> op_mode_out[0])
    else $error("shunt conversion in a mode without shunt");
  a_bus_mode: assert property ($rose(bus_conv_out) |-> op_mode_out[1])
    else $error("bus conversion in a mode without bus");
  a_bus_after_shunt: assert property ($rose(bus_conv_out) |-> !op_mode_out[0]
    || $past(shunt_conv_out) || $past(shunt_conv_out, 2))
    else $error("bus phase not preceded by shunt phase");
  a_trig_holds: assert property (op_mode_out == 3'h1 && $fell(shunt_conv_out)
    |-> !shunt_conv_out [*4])
    else $error("triggered conversion repeated");
  a_cont_repeats: assert property ((op_mode_out == 3'h5) [*3]
    |-> shunt_conv_out || $past(wr_byte_valid_in))
    else $error("continuous shunt conversion stopped");
endmodule

bind mcs_monitor_regs mcs_regs_chk u_chk (
  .clk_in                       (clk_in),
  .sys_rst_in                   (sys_rst_in),
  .wr_byte_valid_in             (wr_byte_valid_in),
  .gen_call_rst_in              (gen_call_rst_in),
  .shunt_conv_out               (shunt_conv_out),
  .bus_conv_out                 (bus_conv_out),
  .bus_range_select_out         (bus_range_select_out),
  .shunt_gain_field_out         (shunt_gain_field_out),
  .bus_conversion_setting_out   (bus_conversion_setting_out),
  .shunt_conversion_setting_out (shunt_conversion_setting_out),
  .op_mode_out                  (op_mode_out)
);

// ---- verif/mcs_host_model.sv ----
// byte-level model of the two-wire host in front of the register bank
// assumes one byte per clock; it drives 1 ns after each rising edge
`timescale 1ns/10ps
module mcs_host_model (
  // clock and read data
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_byte_in,
  // byte requests
  output logic            wr_start_out,
  output logic            wr_byte_valid_out,
  output logic [7:0]      wr_byte_out,
  output logic            rd_start_out,
  output logic            rd_byte_req_out
);
  initial
  begin
    wr_start_out = 1'b0;
    wr_byte_valid_out = 1'b0;
    wr_byte_out = 8'h00;
    rd_start_out = 1'b0;
    rd_byte_req_out = 1'b0;
  end
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  // nbytes 1 sets the pointer only, 3 writes a whole word
  task automatic wr(input logic [7:0] ptr, input logic [15:0] data, input int nbytes);
    logic [23:0] seq;
    seq = {ptr, data};
    step();
    wr_start_out = 1'b1;
    step();
    wr_start_out = 1'b0;
    wr_byte_valid_out = 1'b1;
    repeat (nbytes)
    begin
      wr_byte_out = seq[23:16];
      seq = seq << 8;
      step();
    end
    wr_byte_valid_out = 1'b0;
    // released data lines must not keep the last byte
    wr_byte_out = ~wr_byte_out;
    // a fast host may not read back sooner than 4 us
    repeat (40) step();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [15:0] word);
    wr(ptr, 16'h0000, 1);
    rd_start_out = 1'b1;
    step();
    rd_start_out = 1'b0;
    rd_byte_req_out = 1'b1;
    step();
    word[15:8] = rd_byte_in;
    step();
    rd_byte_req_out = 1'b0;
    word[7:0] = rd_byte_in;
  endtask
endmodule

// ---- verif/mcs_monitor_regs_test.sv ----
// self-checking bench for the monitor register bank
// assumes the host model and the bound checker; front end driven here
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module mcs_monitor_regs_test;
  import mcs_pkg::*;
  logic               clk_in;
  logic               sys_rst_in;
  logic               gcr;
  logic signed [16:0] smp;
  logic               ws, wv, rs, rq, sc, bc, br;
  logic [7:0]         wb, rb;
  logic [1:0]         gain;
  logic [3:0]         bus_conversion_setting, shunt_conversion_setting;
  logic [2:0]         mode;
  logic [15:0]        word;
  int                 fail_count;
  int                 n_tests;
  // short conversion counts keep the run brief
  localparam int      TB_CYC_12BIT = 16;
  localparam int      TB_CYC_AVG2  = 20;
  // length of the latest shunt conversion, in clock cycles
  int                 run_len = 0;
  int                 last_run = 0;
  always @(posedge clk_in)
  begin
    if (sc)
    begin
      run_len <= run_len + 1;
    end
    else if (run_len != 0)
    begin
      last_run <= run_len;
      run_len  <= 0;
    end
  end
  mcs_monitor_regs #(.CYC_12BIT_P(TB_CYC_12BIT), .CYC_AVG2_P(TB_CYC_AVG2)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_start_in(ws), .wr_byte_valid_in(wv),
    .wr_byte_in(wb), .rd_start_in(rs), .rd_byte_req_in(rq), .gen_call_rst_in(gcr),
    .rd_byte_out(rb), .shunt_sample_in(smp), .shunt_conv_out(sc), .bus_conv_out(bc),
    .bus_range_select_out(br), .shunt_gain_field_out(gain),
    .bus_conversion_setting_out(bus_conversion_setting), .shunt_conversion_setting_out(shunt_conversion_setting),
    .op_mode_out(mode)
  );
  mcs_host_model host (
    .clk_in(clk_in), .rd_byte_in(rb), .wr_start_out(ws), .wr_byte_valid_out(wv),
    .wr_byte_out(wb), .rd_start_out(rs), .rd_byte_req_out(rq)
  );
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic summarize;
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_fields;
    host.rd(PTR_CONFIG, word);
    `CHK(word, CONFIG_RESET)
    `CHK(mode, 3'h7)
    smp = -17'sd8001;
    host.wr(PTR_CONFIG, 16'h4CC3, 3);
    `CHK({br, gain}, 3'h1)
    `CHK({bus_conversion_setting, shunt_conversion_setting, mode}, 11'h4C3)
    repeat (60) @(posedge clk_in);
    #1;
    `CHK({sc, bc}, 2'b00)
    host.rd(PTR_CONFIG, word);
    `CHK(word, 16'h4CC3)
    host.rd(PTR_SHUNT, word);
    `CHK(word, 16'hE0C0)
  endtask
  task automatic t_gains;
    logic [15:0] pos_fs [4];
    logic [15:0] neg_fs [4];
    logic [15:0] exp_w;
    int          fs;
    pos_fs = '{16'h0FA0, 16'h1F40, 16'h3E80, 16'h7D00};
    neg_fs = '{16'hF060, 16'hE0C0, 16'hC180, 16'h8300};
    for (int g = 0; g < 4; g++)
    begin
      fs = 4000 << g;
      for (int k = 0; k < 3; k++)
      begin
        smp = (k == 0) ? 17'(fs + 2) : (k == 1) ? 17'(-fs - 2) : -17'sd3998;
        exp_w = (k == 0) ? pos_fs[g] : (k == 1) ? neg_fs[g] : 16'hF062;
        host.wr(PTR_CONFIG, {3'h0, 2'(g), 11'h019}, 3);
        host.rd(PTR_SHUNT, word);
        `CHK(word, exp_w)
      end
    end
    host.wr(PTR_SHUNT, 16'h1234, 3);
    host.rd(PTR_SHUNT, word);
    `CHK(word, 16'hF062)
    host.rd(8'h07, word);
    `CHK(word, 16'h0000)
  endtask
  task automatic t_modes;
    int sh;
    int bs;
    for (int c = 0; c < 16; c++)
    begin
      host.wr(PTR_CONFIG, {5'h00, 4'(c), 4'(c), 3'h0}, 3);
      `CHK({bus_conversion_setting, shunt_conversion_setting}, {4'(c), 4'(c)})
    end
    for (int m = 0; m < 8; m++)
    begin
      host.wr(PTR_CONFIG, {13'h0083, 3'(m)}, 3);
      sh = 0;
      bs = 0;
      repeat (70)
      begin
        @(posedge clk_in);
        #1;
        sh += sc;
        bs += bc;
      end
      `CHK(mode, 3'(m))
      `CHK({sh > 0, bs > 0}, {m[2] & m[0], m[2] & m[1]})
    end
  endtask
  task automatic t_times;
    logic [3:0] codes [5];
    int         lens  [5];
    codes = '{4'h0, 4'h8, 4'h9, 4'h4, 4'h3};
    lens  = '{CYC_9BIT, TB_CYC_12BIT, TB_CYC_AVG2, CYC_9BIT, TB_CYC_12BIT};
    for (int i = 0; i < 5; i++)
    begin
      host.wr(PTR_CONFIG, {9'h000, codes[i], 3'h1}, 3);
      while (sc)
        host.step();
      host.step();
      `CHK(last_run, lens[i])
    end
  endtask
  task automatic t_resets;
    host.wr(PTR_CONFIG, 16'hCCC3, 3);
    host.rd(PTR_CONFIG, word);
    `CHK(word, CONFIG_RESET)
    host.wr(PTR_CONFIG, 16'h4CC3, 3);
    gcr = 1'b1;
    @(posedge clk_in);
    #1;
    gcr = 1'b0;
    host.rd(PTR_CONFIG, word);
    `CHK(word, CONFIG_RESET)
  endtask
  initial
  begin
    sys_rst_in = 1'b1;
    gcr = 1'b0;
    smp = 17'sd0;
    fail_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_fields();
    t_gains();
    t_modes();
    t_times();
    t_resets();
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    summarize();
  end
endmodule
